/* crh_top.sv */
// Reset pin sequencing and host data line multiplexing of the display controller
// Functional notes
// - While internal power-on reset is active the reset pin is pulled low, never driven high.
// - When the internal reset ends the pin is released and becomes an external reset input.
// - An external reset level is acted on only after it stays unchanged 256 oscillator clocks.
// - The sixteen host data lines carry parallel data both ways between host and controller.
// - Without 16-bit parallel mode the upper eight data lines become an 8-bit GPIO port.
// - In serial host mode the lower eight data lines carry the serial host signals.
`include "crh_map.svh"

module crh_top
   import crh_pkg::*;
#(
   parameter int unsigned FILT_CLOCKS = `CRH_FILT_CLOCKS,
   parameter int unsigned POR_CLOCKS = `CRH_POR_CLOCKS
) (
   input wire logic CLK,
   input wire logic RESET_N,
   // Reset pin, open collector
   input wire logic RESET_PIN_IN,
   output logic RESET_PIN_OUT,
   output logic RESET_PIN_OE_N,
   // Core side reset and status
   output logic CORE_RESET_N,
   output logic RESET_DONE,
   output logic EXT_RESET_ACTIVE,
   // Mode selection from the controller's configuration logic
   input wire logic BUS16_MODE,
   input wire logic SERIAL_MODE,
   // Host data lines
   input wire logic [15:0] HOST_DATA_IN,
   output crh_pins_s HOST_DATA_DRV,
   // Parallel bus, core side
   input wire logic [15:0] PAR_WR_DATA,
   input wire logic PAR_DRIVE,
   output logic [15:0] PAR_RD_DATA,
   // General-purpose port on the upper lines
   input wire crh_lane_s GPIO_REQ,
   output logic [7:0] GPIO_IN,
   // Serial host signals on the lower lines
   input wire crh_lane_s SER_REQ,
   output logic [7:0] SER_IN
);

   localparam int unsigned PW = $clog2(POR_CLOCKS + 1);
   localparam logic [PW-1:0] POR_LAST = PW'(POR_CLOCKS - 1);
   localparam logic [PW-1:0] POR_ZERO = PW'(0);
   localparam logic [PW-1:0] POR_ONE = PW'(1);

   crh_state_e state;
   crh_state_e next_state;
   logic [PW-1:0] por_count;
   logic pin_level;
   logic [15:0] din_s1;
   logic [15:0] din_s2;
   logic [15:0] din_s3;
   logic [15:0] din_ok;
   logic core_run;
   crh_pins_s next_drv;

   // Reset pin filter; while we pull the pin low it only tracks our own drive
   crh_level_filter #(
      .CLOCKS(FILT_CLOCKS),
      .RESET_LEVEL(`CRH_PIN_LOW)
   ) u_reset_filter (
      .clk(CLK),
      .reset_n(RESET_N),
      .pin(RESET_PIN_IN),
      .level(pin_level)
   );

   // Power-on reset stretch counter, runs only in the drive state
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         por_count <= POR_ZERO;
      end else if (state == CRH_POR_DRIVE && por_count != POR_LAST) begin
         por_count <= por_count + POR_ONE;
      end
   end

   // Sequencing: drive low, wait for the pin to read high, run, external reset
   always_comb begin
      next_state = state;
      case (state)
         CRH_POR_DRIVE: begin
            if (por_count == POR_LAST) begin
               next_state = CRH_WAIT_HIGH;
            end
         end
         CRH_WAIT_HIGH: begin
            // Filter still holds the low we drove; wait until it sees the pull-up
            if (pin_level == `CRH_PIN_HIGH) begin
               next_state = CRH_RUN;
            end
         end
         CRH_RUN: begin
            if (pin_level == `CRH_PIN_LOW) begin
               next_state = CRH_EXT_RESET;
            end
         end
         CRH_EXT_RESET: begin
            if (pin_level == `CRH_PIN_HIGH) begin
               next_state = CRH_RUN;
            end
         end
         default: begin
            next_state = CRH_POR_DRIVE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= CRH_POR_DRIVE;
      end else begin
         state <= next_state;
      end
   end

   assign core_run = (next_state == CRH_RUN);

   // Open-collector drive: the output value is always low, only the enable moves
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RESET_PIN_OUT <= `CRH_PIN_LOW;
         RESET_PIN_OE_N <= `CRH_OE_ON;
      end else begin
         RESET_PIN_OUT <= `CRH_PIN_LOW;
         RESET_PIN_OE_N <= (next_state == CRH_POR_DRIVE) ? `CRH_OE_ON : `CRH_OE_OFF;
      end
   end

   // Status outputs; RESET_DONE is what host status polling reflects
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CORE_RESET_N <= `CRH_PIN_LOW;
         RESET_DONE <= `CRH_PIN_LOW;
         EXT_RESET_ACTIVE <= `CRH_PIN_LOW;
      end else begin
         CORE_RESET_N <= core_run;
         RESET_DONE <= core_run;
         EXT_RESET_ACTIVE <= (next_state == CRH_EXT_RESET);
      end
   end

   // Host data inputs cross from the pins through three flops
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         din_s1 <= `CRH_LANES_ZERO;
         din_s2 <= `CRH_LANES_ZERO;
         din_s3 <= `CRH_LANES_ZERO;
      end else begin
         din_s1 <= HOST_DATA_IN;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
      end
   end

   // A bit is accepted once the second and third stages agree; else hold it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         din_ok <= `CRH_LANES_ZERO;
      end else begin
         din_ok <= (din_s3 & ~(din_s2 ^ din_s3)) | (din_ok & (din_s2 ^ din_s3));
      end
   end

   // Lane drive selection; nothing is driven while the core is held in reset
   always_comb begin
      next_drv.data = `CRH_LANES_ZERO;
      next_drv.oe_n = `CRH_LANES_OFF;
      if (core_run) begin
         // Upper byte: parallel data in 16-bit mode, otherwise the GPIO port
         if (BUS16_MODE) begin
            next_drv.data[`CRH_HI_MSB:`CRH_HI_LSB] = PAR_WR_DATA[`CRH_HI_MSB:`CRH_HI_LSB];
            next_drv.oe_n[`CRH_HI_MSB:`CRH_HI_LSB] = {`CRH_BYTE_W{~PAR_DRIVE}};
         end else begin
            next_drv.data[`CRH_HI_MSB:`CRH_HI_LSB] = GPIO_REQ.data;
            next_drv.oe_n[`CRH_HI_MSB:`CRH_HI_LSB] = ~GPIO_REQ.drive;
         end
         // Lower byte: serial host signals take precedence over parallel data
         if (SERIAL_MODE) begin
            next_drv.data[`CRH_LO_MSB:`CRH_LO_LSB] = SER_REQ.data;
            next_drv.oe_n[`CRH_LO_MSB:`CRH_LO_LSB] = ~SER_REQ.drive;
         end else begin
            next_drv.data[`CRH_LO_MSB:`CRH_LO_LSB] = PAR_WR_DATA[`CRH_LO_MSB:`CRH_LO_LSB];
            next_drv.oe_n[`CRH_LO_MSB:`CRH_LO_LSB] = {`CRH_BYTE_W{~PAR_DRIVE}};
         end
      end
   end

   // Registered pin drive keeps the pads glitch-free between mode changes
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         HOST_DATA_DRV.data <= `CRH_LANES_ZERO;
         HOST_DATA_DRV.oe_n <= `CRH_LANES_OFF;
      end else begin
         HOST_DATA_DRV <= next_drv;
      end
   end

   // Received data is routed to the user that owns each byte lane
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PAR_RD_DATA <= `CRH_LANES_ZERO;
         GPIO_IN <= `CRH_BYTE_ZERO;
         SER_IN <= `CRH_BYTE_ZERO;
      end else begin
         PAR_RD_DATA[`CRH_HI_MSB:`CRH_HI_LSB] <= BUS16_MODE ?
            din_ok[`CRH_HI_MSB:`CRH_HI_LSB] : `CRH_BYTE_ZERO;
         GPIO_IN <= BUS16_MODE ? `CRH_BYTE_ZERO : din_ok[`CRH_HI_MSB:`CRH_HI_LSB];
         PAR_RD_DATA[`CRH_LO_MSB:`CRH_LO_LSB] <= SERIAL_MODE ?
            `CRH_BYTE_ZERO : din_ok[`CRH_LO_MSB:`CRH_LO_LSB];
         SER_IN <= SERIAL_MODE ? din_ok[`CRH_LO_MSB:`CRH_LO_LSB] : `CRH_BYTE_ZERO;
      end
   end

endmodule

/* crh_map.svh */
// Constants for the controller reset and host data pin logic
`ifndef CRH_MAP_SVH
`define CRH_MAP_SVH

// Core reference clock rate and period
`define CRH_CLK_MHZ 50
`define CRH_CLK_PERIOD_NS 20

// Stable-level filter length for the reset pin, in core reference clocks
`define CRH_FILT_CLOCKS 256
// Internal power-on reset stretch after RESET_N release, in core reference clocks
`define CRH_POR_CLOCKS 256

// Host data line layout
`define CRH_HOST_W 16
`define CRH_BYTE_W 8
`define CRH_HI_MSB 15
`define CRH_HI_LSB 8
`define CRH_LO_MSB 7
`define CRH_LO_LSB 0

// Pin levels and idle values
`define CRH_PIN_HIGH 1'b1
`define CRH_PIN_LOW 1'b0
`define CRH_OE_OFF 1'b1
`define CRH_OE_ON 1'b0
`define CRH_LANES_OFF 16'hFFFF
`define CRH_LANES_ZERO 16'h0000
`define CRH_BYTE_ZERO 8'h00

`endif

/* crh_pkg.sv */
// Types shared by the controller reset and host data pin logic
package crh_pkg;

   // Reset sequencing states
   typedef enum logic [1:0] {
      CRH_POR_DRIVE,
      CRH_WAIT_HIGH,
      CRH_RUN,
      CRH_EXT_RESET
   } crh_state_e;

   // Drive side of the sixteen host data lines (output enable active low)
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] oe_n;
   } crh_pins_s;

   // One byte lane of user-side drive request (direction 1 = drive)
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] drive;
   } crh_lane_s;

endpackage

/* crh_level_filter.sv */
// Three-stage synchroniser and stable-level filter for one pin
`include "crh_map.svh"

module crh_level_filter
   import crh_pkg::*;
#(
   parameter int unsigned CLOCKS = `CRH_FILT_CLOCKS,
   parameter logic RESET_LEVEL = `CRH_PIN_HIGH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pin,
   output logic level
);

   localparam int unsigned CW = $clog2(CLOCKS + 1);
   localparam logic [CW-1:0] LAST = CW'(CLOCKS - 1);
   localparam logic [CW-1:0] ZERO = CW'(0);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic s1;
   logic s2;
   logic s3;
   logic [CW-1:0] count;

   // Three flops; only s2 and s3 are looked at, s1 feeds s2 alone
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1 <= RESET_LEVEL;
         s2 <= RESET_LEVEL;
         s3 <= RESET_LEVEL;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A new level is taken only after CLOCKS agreed samples in a row
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= ZERO;
         level <= RESET_LEVEL;
      end else if (s2 != s3 || s3 == level) begin
         count <= ZERO;
      end else if (count == LAST) begin
         count <= ZERO;
         level <= s3;
      end else begin
         count <= count + ONE;
      end
   end

endmodule

/* crh_top_monitor.sv */
// Port checker for the reset pin and host data line logic
module crh_top_monitor
   import crh_pkg::*;
#(
   parameter int unsigned FILT_CLOCKS = 256
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic RESET_PIN_IN,
   input wire logic RESET_PIN_OUT,
   input wire logic RESET_PIN_OE_N,
   input wire logic CORE_RESET_N,
   input wire logic RESET_DONE,
   input wire logic EXT_RESET_ACTIVE,
   input wire logic BUS16_MODE,
   input wire logic SERIAL_MODE,
   input wire logic PAR_DRIVE,
   input wire logic [15:0] PAR_WR_DATA,
   input wire crh_pins_s HOST_DATA_DRV,
   input wire crh_lane_s GPIO_REQ,
   input wire crh_lane_s SER_REQ
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned low_run = 0;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // Low run length of the pin; saturates so it never wraps
   always_ff @(posedge CLK) begin
      if (RESET_PIN_IN)
         low_run <= 0;
      else if (low_run < 1000)
         low_run <= low_run + 1;
   end
   chk_pin_never_high: assert property (RESET_PIN_OUT == 1'b0)
      else $error("reset pin driven high");
   chk_run_pin_free: assert property (CORE_RESET_N |-> RESET_PIN_OE_N)
      else $error("pin pulled while core runs");
   chk_done_tracks: assert property (RESET_DONE == CORE_RESET_N)
      else $error("status differs from core reset");
   chk_ext_filter: assert property ($fell(CORE_RESET_N) |-> low_run >= FILT_CLOCKS)
      else $error("external reset taken too soon");
   chk_ext_holds: assert property (EXT_RESET_ACTIVE |-> !CORE_RESET_N && RESET_PIN_OE_N)
      else $error("external reset not holding core");
   chk_bus16_drive: assert property (CORE_RESET_N && $past(BUS16_MODE && PAR_DRIVE
      && !SERIAL_MODE) |-> HOST_DATA_DRV.oe_n == 16'h0000
      && HOST_DATA_DRV.data == $past(PAR_WR_DATA))
      else $error("parallel drive wrong");
   chk_gpio_upper: assert property (CORE_RESET_N && $past(!BUS16_MODE)
      |-> HOST_DATA_DRV.oe_n[15:8] == ~$past(GPIO_REQ.drive))
      else $error("upper lanes not port");
   chk_serial_lower: assert property (CORE_RESET_N && $past(SERIAL_MODE)
      |-> HOST_DATA_DRV.oe_n[7:0] == ~$past(SER_REQ.drive))
      else $error("lower lanes not serial");
   chk_idle_lines: assert property (!CORE_RESET_N |-> HOST_DATA_DRV.oe_n == 16'hFFFF)
      else $error("lines driven in reset");
   cov_ext: cover property ($rose(EXT_RESET_ACTIVE));
   cov_gpio: cover property (CORE_RESET_N && !BUS16_MODE);
   cov_ser: cover property (CORE_RESET_N && SERIAL_MODE);
endmodule

/* crh_host_model.sv */
// Host-side model: reset pin wire, host data lines and start-up wait
module crh_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_oe_n,
   input wire logic host_rst_low,
   input wire logic done,
   input wire logic [15:0] drv_data,
   input wire logic [15:0] drv_oe_n,
   input wire logic [15:0] host_val,
   output logic pin,
   output logic [15:0] lines,
   output logic ready
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned waited = 0;
   // Pull-up wins unless someone sinks the open-collector pin
   assign pin = !(pin_oe_n === 1'b0 || host_rst_low);
   // Host drives every line the controller has released
   assign lines = (drv_oe_n & host_val) | (~drv_oe_n & drv_data);
   // Start-up wait restarts with every rst_n reset
   always_ff @(posedge clk) begin
      if (!rst_n)
         waited <= 0;
      else if (waited < 256)
         waited <= waited + 1;
   end
   assign ready = waited >= 256 && done === 1'b1;
endmodule

/* testbench.sv */
// Self-checking bench for the reset pin and host data line logic
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import crh_pkg::*;
   typedef struct packed {
      logic b16, ser, drv;
      logic [15:0] wr;
      crh_lane_s g, s;
      logic [15:0] hv, oe, dat, rd;
      logic [7:0] gi, si;
   } crh_row_s;
   localparam int unsigned FILT = 8;
   logic clk = 0, rst_n = 0, rst_low = 0, b16 = 1, ser = 0, drv = 0, pin;
   logic pin_out, pin_oe_n, core_n, done, ext, ready;
   logic [15:0] wr = 16'h0000, hv = 16'h0000, lines, rd;
   logic [7:0] gi, si;
   crh_lane_s g = 16'h0000, s = 16'h0000;
   crh_pins_s dq;
   int err_total = 0, compares = 0, n;
   crh_row_s rows [4] = '{
      '{1'b1, 1'b0, 1'b1, 16'hA5C3, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'hA5C3, 16'hA5C3, 8'h00, 8'h00},
      '{1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h1234,
        16'hFFFF, 16'h0000, 16'h1234, 8'h00, 8'h00},
      '{1'b0, 1'b0, 1'b0, 16'h0000, 16'h5A0F, 16'h0000, 16'hC300,
        16'hF0FF, 16'h0A00, 16'h0000, 8'hCA, 8'h00},
      '{1'b1, 1'b1, 1'b1, 16'hBEEF, 16'h0000, 16'h3CF0, 16'h0005,
        16'h000F, 16'hBE30, 16'hBE00, 8'h00, 8'h35}};
   crh_top #(.FILT_CLOCKS(FILT), .POR_CLOCKS(4)) DUT (.CLK(clk), .RESET_N(rst_n),
      .RESET_PIN_IN(pin), .RESET_PIN_OUT(pin_out), .RESET_PIN_OE_N(pin_oe_n),
      .CORE_RESET_N(core_n), .RESET_DONE(done), .EXT_RESET_ACTIVE(ext), .BUS16_MODE(b16),
      .SERIAL_MODE(ser), .HOST_DATA_IN(lines), .HOST_DATA_DRV(dq), .PAR_WR_DATA(wr),
      .PAR_DRIVE(drv), .PAR_RD_DATA(rd), .GPIO_REQ(g), .GPIO_IN(gi), .SER_REQ(s), .SER_IN(si));
   crh_host_model host (.clk(clk), .rst_n(rst_n), .pin_oe_n(pin_oe_n), .host_rst_low(rst_low),
      .done(done), .drv_data(dq.data), .drv_oe_n(dq.oe_n), .host_val(hv), .pin(pin),
      .lines(lines), .ready(ready));
   // Free-running core clock
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
      compares++;
      if (got !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, got);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Power-on sequence; the pull is checked while it must still stand
   task por_seq;
      rst_n = 0;
      repeat (6) @(negedge clk);
      chk("pin_oe_n", 16'h0000, pin_oe_n);
      chk("pin_out", 16'h0000, pin_out);
      rst_n = 1;
      @(negedge clk);
      chk("pin_oe_n", 16'h0000, pin_oe_n);
      for (n = 0; n < 2000 && ready !== 1'b1; n++) @(negedge clk);
      chk("ready", 16'h0001, ready);
      chk("pin_oe_n", 16'h0001, pin_oe_n);
      $display("power-on test done");
   endtask
   task pull_low(input int c);
      rst_low = 1;
      repeat (c) @(negedge clk);
      rst_low = 0;
   endtask
   initial begin
      @(negedge clk);
      por_seq();
      foreach (rows[i]) begin
         {b16, ser, drv, wr, g, s, hv} = {rows[i].b16, rows[i].ser, rows[i].drv,
            rows[i].wr, rows[i].g, rows[i].s, rows[i].hv};
         repeat (7) @(negedge clk);
         chk("oe_n", rows[i].oe, dq.oe_n);
         chk("data", rows[i].dat, dq.data & ~dq.oe_n);
         chk("par_rd", rows[i].rd, rd);
         chk("gpio_in", {8'h00, rows[i].gi}, {8'h00, gi});
         chk("ser_in", {8'h00, rows[i].si}, {8'h00, si});
         $display("row %0d done", i);
      end
      // Two short pulses with a gap: each alone is below the filter length
      pull_low(FILT - 2);
      repeat (2) @(negedge clk);
      pull_low(FILT - 2);
      repeat (FILT + 6) @(negedge clk);
      chk("core_n", 16'h0001, core_n);
      pull_low(FILT + 8);
      chk("ext", 16'h0001, ext);
      chk("core_n", 16'h0000, core_n);
      chk("oe_n", 16'hFFFF, dq.oe_n);
      for (n = 0; n < 100 && core_n !== 1'b1; n++) @(negedge clk);
      chk("ext", 16'h0000, ext);
      $display("external reset test done");
      por_seq();
      tally_and_finish();
   end
   // Watchdog, well past the expected run time
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule
bind crh_top crh_top_monitor #(.FILT_CLOCKS(FILT_CLOCKS)) u_mon (.CLK(CLK), .RESET_N(RESET_N),
   .RESET_PIN_IN(RESET_PIN_IN), .RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE_N(RESET_PIN_OE_N),
   .CORE_RESET_N(CORE_RESET_N), .RESET_DONE(RESET_DONE), .EXT_RESET_ACTIVE(EXT_RESET_ACTIVE),
   .BUS16_MODE(BUS16_MODE), .SERIAL_MODE(SERIAL_MODE), .PAR_DRIVE(PAR_DRIVE),
   .PAR_WR_DATA(PAR_WR_DATA), .HOST_DATA_DRV(HOST_DATA_DRV), .GPIO_REQ(GPIO_REQ),
   .SER_REQ(SER_REQ));
